//--- design/fst_consts.svh
// Register map, field positions, codes and status words of the command interpreter
`ifndef FST_CONSTS_SVH
`define FST_CONSTS_SVH
// ==========================================================
// Register byte addresses
`define FST_A_CMD      8'h00
`define FST_A_TGT      8'h04
`define FST_A_LEN      8'h08
`define FST_A_TOT      8'h0c
`define FST_A_STAT     8'h10
`define FST_A_FCFG     8'h14
`define FST_A_FQRY     8'h18
`define FST_A_INFO     8'h1c
// ==========================================================
// Field positions
`define FST_F_KIND     1:0
`define FST_B_DATA     2
`define FST_B_LE       3
`define FST_F_P1       15:8
`define FST_F_P2       23:16
`define FST_F_CMDK     23:0
`define FST_F_IDX      7:0
`define FST_B_ACC      8
`define FST_B_APP      9
`define FST_F_DIR      23:16
`define FST_F_TAG      31:24
`define FST_F_LC       8:0
`define FST_F_LEV      24:16
`define FST_F_TOTD     15:0
`define FST_F_TOTR     31:16
`define FST_F_ENT      9:8
`define FST_F_FN       10:8
// ==========================================================
// Parameter byte codes
`define FST_P1_FID     8'h00
`define FST_P1_ROOT    8'h08
`define FST_P1_DIR     8'h09
`define FST_P1_NOALG   8'h00
`define FST_P2_NONE    8'h00
`define FST_P2_RFU     8'h60
`define FST_B_SPEC     7
`define FST_F_KNUM     4:0
`define FST_F_BLK      7:5
`define FST_BLK_DFIRST 3'b100
`define FST_BLK_DNEXT  3'b000
`define FST_BLK_DRETX  3'b010
`define FST_BLK_RFIRST 3'b101
`define FST_BLK_RNEXT  3'b001
`define FST_BLK_RRETX  3'b011
`define FST_TAG_CON    8'h73
`define FST_TAG_PRIM   8'h53
`define FST_MAX_BLK    9'h0ff
`define FST_LEN_NONE   9'h000
// ==========================================================
// Status words
`define FST_SW_OK      16'h9000
`define FST_SW_DMORE   16'h63f1
`define FST_SW_DDONE   16'h62f3
`define FST_SW_RMORE   16'h62f1
`define FST_SW_SEC     16'h6982
`define FST_SW_COND    16'h6985
`define FST_SW_P1P2    16'h6a86
`define FST_SW_NOFILE  16'h6a82
`define FST_SW_LEN     16'h6700
`define FST_SW_TAG     16'h6a80
`endif

//--- design/fst_pkg.sv
// Types shared by the command interpreter modules
package fst_pkg;
  typedef enum logic [2:0] {
    FST_IDLE,
    FST_FETCH,
    FST_EXEC,
    FST_QFETCH,
    FST_QEXEC,
    FST_CALC
  } fst_state_e;
  typedef enum logic [1:0] {
    FST_K_SUSPEND,
    FST_K_RESUME,
    FST_K_AUTH_EVEN,
    FST_K_AUTH_ODD
  } fst_kind_e;
  typedef enum logic [2:0] {
    FST_FN_SELECT,
    FST_FN_RESUME,
    FST_FN_READ,
    FST_FN_UPDATE,
    FST_FN_OTHER
  } fst_func_e;
  typedef struct packed {
    logic avail_b7;
    logic deact;
  } fst_entry_s;
  typedef logic [15:0] fst_cnt_t;
endpackage : fst_pkg

//--- design/fst_if.sv
// Interfaces between the interpreter, its file table and its compute engine
`timescale 1ns/1ps
`default_nettype none
interface fst_mem_if #(
  parameter int AW = 8
);
  logic               we;
  logic [AW-1:0]      waddr;
  fst_pkg::fst_entry_s wdata;
  logic [AW-1:0]      raddr;
  fst_pkg::fst_entry_s rdata;
  modport ctl (output we, waddr, wdata, raddr, input rdata);
  modport mem (input we, waddr, wdata, raddr, output rdata);
endinterface : fst_mem_if

interface fst_calc_if;
  logic start;
  logic done;
  modport ctl (output start, input done);
  modport eng (input start, output done);
endinterface : fst_calc_if
`default_nettype wire

//--- design/fst_mem.sv
// File lifecycle table with registered read data
`timescale 1ns/1ps
`default_nettype none
module fst_mem #(
  parameter int AW    = 8,
  parameter int DEPTH = 256
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  fst_mem_if.mem    m
);
  import fst_pkg::*;
  typedef struct packed {
    fst_entry_s [DEPTH-1:0] ram;
    fst_entry_s             rd;
  } fst_mem_s;
  fst_mem_s q;
  fst_mem_s n;
  if (DEPTH < 1 || DEPTH > (1 << AW))
  begin : g_chk
    $error("fst_mem: DEPTH does not fit AW");
  end
  // Read during write returns the old entry
  always_comb
  begin
    n = q;
    if (m.we && int'(m.waddr) < DEPTH)
      n.ram[m.waddr] = m.wdata;
    n.rd = (int'(m.raddr) < DEPTH) ? q.ram[m.raddr] : '0;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q <= '0;
    else
      q <= n;
  end
  assign m.rdata = q.rd;
endmodule : fst_mem
`default_nettype wire

//--- design/fst_calc.sv
// Authentication compute engine stand-in: busy for a fixed number of cycles
`timescale 1ns/1ps
`default_nettype none
module fst_calc #(
  parameter int CALC_CYCLES = 16
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  fst_calc_if.eng   cal
);
  import fst_pkg::*;
  localparam int CW = $clog2(CALC_CYCLES + 1);
  typedef struct packed {
    logic          busy;
    logic [CW-1:0] cnt;
  } fst_calc_s;
  fst_calc_s q;
  fst_calc_s n;
  if (CALC_CYCLES < 1)
  begin : g_chk
    $error("fst_calc: CALC_CYCLES must be at least 1");
  end
  always_comb
  begin
    n = q;
    cal.done = 1'b0;
    if (q.busy)
    begin
      if (q.cnt == CW'(CALC_CYCLES - 1))
      begin
        n.busy = 1'b0;
        cal.done = 1'b1;
      end
      else
        n.cnt = q.cnt + 1'b1;
    end
    else if (cal.start)
    begin
      n.busy = 1'b1;
      n.cnt = '0;
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q <= '0;
    else
      q <= n;
  end
endmodule : fst_calc
`default_nettype wire

//--- design/fst_top.sv
// Command interpreter for file suspend, file resume and authentication
//
// Local design decisions: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "fst_consts.svh"
// ==========================================================
// Operation
// R1: Suspend marks file deactivated, flag updated
// R2: Suspend only when its access condition holds
// R3: Successful command makes target the current file
// R4: Failure leaves current file and directory unchanged
// R5: Deactivated plain file allows only select, resume
// R6: Deactivated file with b7 still readable, updatable
// R7: P1 selects by id, path from root, path
// R8: P2 zero; empty P1/P2/data targets current file
// R9: Resume returns file to active, flag updated
// R10: Resume only when its access condition holds
// R11: Terminal selects application before authenticating
// R12: Even form only short untagged challenge
// R13: Odd form uses tags 73 or 53
// R14: Data blocks at most 255, concatenated
// R15: Missing segments answer 63F1, complete 62F3
// R16: Computation starts at first response request
// R17: Response segments answer 62F1, last 9000
// R18: Retransmit repeats all parameters except P1
// R19: Data blocks without Le, response requests without data
// R20: Even form P1 zero means implied algorithm
// R21: P2 gives key scope, number, reserved bits zero
// R22: Odd P1 top bits encode block kind
// R23: Reserved P1 or P2 rejected, nothing changes; a reserved odd block kind still loads the key field
// ==========================================================
module fst_top #(
  parameter int IDXW        = 8,
  parameter int DEPTH       = 256,
  parameter int CALC_CYCLES = 16
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o
);
  import fst_pkg::*;
  if (IDXW < 1 || IDXW > 8 || DEPTH < 1 || DEPTH > (1 << IDXW))
  begin : g_chk
    $error("fst_top: IDXW or DEPTH out of range");
  end
  // ==========================================================
  // State
  typedef struct packed {
    fst_state_e      st;
    logic            ack;
    logic [31:0]     rdat;
    logic [15:0]     sw;
    logic [31:0]     cmd;
    logic [31:0]     tgt;
    logic [31:0]     len;
    logic [31:0]     tot;
    logic [IDXW-1:0] cur_file;
    logic [7:0]      cur_dir;
    logic [IDXW-1:0] fidx;
    logic [2:0]      qfn;
    logic            qres;
    logic            dphase;
    logic            ddone;
    logic            cdone;
    logic            rphase;
    fst_cnt_t        dcnt;
    fst_cnt_t        dprev;
    fst_cnt_t        roff;
    fst_cnt_t        rprev;
    logic [5:0]      key;
  } fst_top_s;
  fst_top_s q;
  fst_top_s n;
  fst_mem_if #(.AW(IDXW)) memb ();
  fst_calc_if             calb ();
  logic        acc;
  logic [31:0] wc;
  fst_kind_e   kind;
  fst_func_e   qfn;
  logic [7:0]  p1;
  logic [7:0]  p2;
  logic [2:0]  blk;
  logic [8:0]  lc;
  logic [8:0]  le;
  logic        datap;
  logic        lep;
  logic        fcmd;
  logic        p1ok;
  logic        p2bad;
  logic        app;
  fst_cnt_t    totd;
  fst_cnt_t    totr;
  logic        dblk;
  logic        rblk;
  // ==========================================================
  // Helpers
  function automatic logic [31:0] bmerge(input logic [31:0] o,
                                         input logic [31:0] w,
                                         input logic [3:0]  s);
    for (int i = 0; i < 4; i++)
      bmerge[i*8 +: 8] = s[i] ? w[i*8 +: 8] : o[i*8 +: 8];
  endfunction : bmerge
  function automatic logic idx_ok(input logic [IDXW-1:0] i);
    return int'(i) < DEPTH;
  endfunction : idx_ok
  // Next offset after one segment of at most l bytes
  function automatic fst_cnt_t seg(input fst_cnt_t   off,
                                   input logic [8:0] l,
                                   input fst_cnt_t   t);
    fst_cnt_t rem;
    rem = (t > off) ? fst_cnt_t'(t - off) : '0;
    return fst_cnt_t'(off + ((fst_cnt_t'(l) < rem) ? fst_cnt_t'(l) : rem));
  endfunction : seg
  assign acc = wb_cyc_i & wb_stb_i;
  assign wc = bmerge('0, wb_dat_i, wb_sel_i);
  assign kind = fst_kind_e'(q.cmd[`FST_F_KIND]);
  assign qfn = fst_func_e'(q.qfn);
  assign p1 = q.cmd[`FST_F_P1];
  assign p2 = q.cmd[`FST_F_P2];
  // R22: block kind field
  assign blk = p1[`FST_F_BLK];
  assign lc = q.len[`FST_F_LC];
  assign le = q.len[`FST_F_LEV];
  assign datap = q.cmd[`FST_B_DATA];
  assign lep = q.cmd[`FST_B_LE];
  assign fcmd = (kind == FST_K_SUSPEND) || (kind == FST_K_RESUME);
  // R7: selection control decode
  assign p1ok = (p1 == `FST_P1_FID) || (p1 == `FST_P1_ROOT) || (p1 == `FST_P1_DIR);
  // R21: reserved key bits
  assign p2bad = (p2 & `FST_P2_RFU) != 8'h00;
  assign app = q.tgt[`FST_B_APP];
  assign totd = q.tot[`FST_F_TOTD];
  assign totr = q.tot[`FST_F_TOTR];
  assign memb.raddr = q.fidx;
  // ==========================================================
  // Next state
  always_comb
  begin
    n = q;
    n.ack = 1'b0;
    dblk = 1'b0;
    rblk = 1'b0;
    memb.we = 1'b0;
    memb.waddr = q.fidx;
    memb.wdata = '0;
    calb.start = 1'b0;
    unique case (q.st)
      FST_IDLE:
        n.st = FST_IDLE;
      FST_FETCH:
        n.st = FST_EXEC;
      FST_QFETCH:
        n.st = FST_QEXEC;
      FST_QEXEC:
      begin
        n.st = FST_IDLE;
        // R5: R6: availability of a deactivated file
        n.qres = idx_ok(q.fidx) && (!memb.rdata.deact
                 || qfn == FST_FN_SELECT || qfn == FST_FN_RESUME
                 || (memb.rdata.avail_b7 && (qfn == FST_FN_READ || qfn == FST_FN_UPDATE)));
      end
      FST_CALC:
      begin
        if (calb.done)
        begin
          n.st = FST_IDLE;
          n.cdone = 1'b1;
          n.sw = `FST_SW_OK;
          if (kind == FST_K_AUTH_ODD)
          begin
            n.rprev = '0;
            n.roff = seg('0, le, totr);
            rblk = 1'b1;
          end
        end
      end
      FST_EXEC:
      begin
        n.st = FST_IDLE;
        if (fcmd)
        begin
          // R23: R8: R4: refusals keep selection
          if (!p1ok || p2 != `FST_P2_NONE)
            n.sw = `FST_SW_P1P2;
          else if (!idx_ok(q.fidx))
            n.sw = `FST_SW_NOFILE;
          // R2: R10: access condition gate
          else if (!q.tgt[`FST_B_ACC])
            n.sw = `FST_SW_SEC;
          else
          begin
            // R1: R9: lifecycle flag update
            memb.we = 1'b1;
            memb.wdata.avail_b7 = memb.rdata.avail_b7;
            memb.wdata.deact = (kind == FST_K_SUSPEND);
            // R3: target becomes current
            n.cur_file = q.fidx;
            if (p1 != `FST_P1_FID)
              n.cur_dir = q.tgt[`FST_F_DIR];
            n.sw = `FST_SW_OK;
          end
        end
        // R11: no application, no authentication
        else if (!app)
          n.sw = `FST_SW_COND;
        else if (p2bad)
          n.sw = `FST_SW_P1P2;
        else if (kind == FST_K_AUTH_EVEN)
        begin
          // R20: implied algorithm only
          if (p1 != `FST_P1_NOALG)
            n.sw = `FST_SW_P1P2;
          // R12: short challenge only
          else if (!datap || lc == `FST_LEN_NONE || lc > `FST_MAX_BLK)
            n.sw = `FST_SW_LEN;
          else
          begin
            n.key = {p2[`FST_B_SPEC], p2[`FST_F_KNUM]};
            n.dphase = 1'b0;
            n.ddone = 1'b0;
            n.rphase = 1'b0;
            n.cdone = 1'b0;
            calb.start = 1'b1;
            n.st = FST_CALC;
          end
        end
        // R19: presence of data and Le by block kind
        else if (blk[0] ? (datap || !lep)
                        : (!datap || lep || lc == `FST_LEN_NONE || lc > `FST_MAX_BLK))
          n.sw = `FST_SW_LEN;
        else
        begin
          n.key = {p2[`FST_B_SPEC], p2[`FST_F_KNUM]};
          unique case (blk)
            `FST_BLK_DFIRST:
            begin
              // R13: outer tag check
              if (q.tgt[`FST_F_TAG] != `FST_TAG_CON && q.tgt[`FST_F_TAG] != `FST_TAG_PRIM)
                n.sw = `FST_SW_TAG;
              else
              begin
                n.dprev = '0;
                n.dcnt = fst_cnt_t'(lc);
                n.dphase = 1'b1;
                n.rphase = 1'b0;
                n.cdone = 1'b0;
                dblk = 1'b1;
              end
            end
            `FST_BLK_DNEXT:
            begin
              if (!q.dphase || q.ddone)
                n.sw = `FST_SW_COND;
              else
              begin
                // R14: blocks concatenate in order
                n.dprev = q.dcnt;
                n.dcnt = fst_cnt_t'(q.dcnt + fst_cnt_t'(lc));
                dblk = 1'b1;
              end
            end
            `FST_BLK_DRETX:
            begin
              if (!q.dphase)
                n.sw = `FST_SW_COND;
              else
              begin
                // R18: previous block replaced
                n.dcnt = fst_cnt_t'(q.dprev + fst_cnt_t'(lc));
                dblk = 1'b1;
              end
            end
            `FST_BLK_RFIRST:
            begin
              if (!q.ddone)
                n.sw = `FST_SW_COND;
              else
              begin
                // R16: compute on first response
                calb.start = 1'b1;
                n.rphase = 1'b0;
                n.cdone = 1'b0;
                n.st = FST_CALC;
              end
            end
            `FST_BLK_RNEXT:
            begin
              if (!q.rphase)
                n.sw = `FST_SW_COND;
              else
              begin
                n.rprev = q.roff;
                n.roff = seg(q.roff, le, totr);
                rblk = 1'b1;
              end
            end
            `FST_BLK_RRETX:
            begin
              if (!q.cdone)
                n.sw = `FST_SW_COND;
              else
              begin
                n.roff = seg(q.rprev, le, totr);
                rblk = 1'b1;
              end
            end
            default:
              n.sw = `FST_SW_P1P2;
          endcase
        end
      end
    endcase
    // R15: data progress status
    if (dblk)
    begin
      n.ddone = n.dcnt >= totd;
      n.sw = n.ddone ? `FST_SW_DDONE : `FST_SW_DMORE;
    end
    // R17: response progress status
    if (rblk)
    begin
      n.rphase = n.roff < totr;
      n.sw = n.rphase ? `FST_SW_RMORE : `FST_SW_OK;
    end
    // Bus: read data loads with ack, writes land on the edge that ends ack
    if (acc && !q.ack)
    begin
      n.ack = 1'b1;
      unique case (wb_adr_i)
        `FST_A_CMD:  n.rdat = {q.st != FST_IDLE, 7'h00, q.cmd[`FST_F_CMDK]};
        `FST_A_TGT:  n.rdat = q.tgt;
        `FST_A_LEN:  n.rdat = q.len;
        `FST_A_TOT:  n.rdat = q.tot;
        `FST_A_STAT: n.rdat = {q.cur_dir, 8'(q.cur_file), q.sw};
        `FST_A_FQRY: n.rdat = {18'h0, q.key, 4'h0, q.cdone, q.rphase, q.ddone, q.qres};
        `FST_A_INFO: n.rdat = {q.roff, q.dcnt};
        default:     n.rdat = '0;
      endcase
    end
    // Writes while busy are acknowledged but dropped, so a command cannot be torn
    if (acc && q.ack && wb_we_i && q.st == FST_IDLE)
    begin
      unique case (wb_adr_i)
        `FST_A_CMD:
        begin
          n.cmd = {8'h00, wc[`FST_F_CMDK]};
          // R8: empty selection means current file
          n.fidx = (wc[`FST_F_P1] == `FST_P1_FID && !wc[`FST_B_DATA])
                   ? q.cur_file : IDXW'(q.tgt[`FST_F_IDX]);
          n.st = FST_FETCH;
        end
        `FST_A_TGT: n.tgt = bmerge(q.tgt, wb_dat_i, wb_sel_i);
        `FST_A_LEN: n.len = bmerge(q.len, wb_dat_i, wb_sel_i);
        `FST_A_TOT: n.tot = bmerge(q.tot, wb_dat_i, wb_sel_i);
        `FST_A_FCFG:
        begin
          memb.we = 1'b1;
          memb.waddr = IDXW'(wc[`FST_F_IDX]);
          memb.wdata = fst_entry_s'(wc[`FST_F_ENT]);
        end
        `FST_A_FQRY:
        begin
          n.fidx = IDXW'(wc[`FST_F_IDX]);
          n.qfn = wc[`FST_F_FN];
          n.st = FST_QFETCH;
        end
        default:
          n.st = FST_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      q.sw <= `FST_SW_OK;
    end
    else
      q <= n;
  end
  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.rdat;
  fst_mem #(.AW(IDXW), .DEPTH(DEPTH)) u_mem (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .m     (memb.mem)
  );
  fst_calc #(.CALC_CYCLES(CALC_CYCLES)) u_calc (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .cal   (calb.eng)
  );
  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_susp_flag;
    q.st == FST_EXEC && kind == FST_K_SUSPEND && memb.we |-> memb.wdata.deact ##1 q.sw == `FST_SW_OK;
  endproperty
  a_susp_flag: assert property (p_susp_flag) else $error("suspend did not set flag"); // R1
  property p_resume_flag;
    q.st == FST_EXEC && kind == FST_K_RESUME && memb.we
      |-> !memb.wdata.deact && memb.wdata.avail_b7 == memb.rdata.avail_b7;
  endproperty
  a_resume_flag: assert property (p_resume_flag) else $error("resume flag wrong"); // R9
  property p_susp_acc;
    q.st == FST_EXEC && kind == FST_K_SUSPEND && !q.tgt[`FST_B_ACC] |-> !memb.we;
  endproperty
  a_susp_acc: assert property (p_susp_acc) else $error("suspend without access"); // R2
  property p_resume_acc;
    q.st == FST_EXEC && kind == FST_K_RESUME && !q.tgt[`FST_B_ACC] |=> q.sw != `FST_SW_OK;
  endproperty
  a_resume_acc: assert property (p_resume_acc) else $error("resume without access"); // R10
  property p_cur_file;
    q.st == FST_EXEC && fcmd && memb.we |=> q.cur_file == $past(q.fidx) && q.st == FST_IDLE;
  endproperty
  a_cur_file: assert property (p_cur_file) else $error("current file not updated"); // R3
  property p_keep_sel;
    q.st == FST_EXEC && fcmd && !memb.we |=> $stable(q.cur_file) && $stable(q.cur_dir);
  endproperty
  a_keep_sel: assert property (p_keep_sel) else $error("selection changed on failure"); // R4
  property p_rfu;
    q.st == FST_EXEC && fcmd && !p1ok |-> !memb.we ##1 q.sw == `FST_SW_P1P2;
  endproperty
  a_rfu: assert property (p_rfu) else $error("reserved P1 accepted"); // R23
  property p_plain_deact;
    q.st == FST_QEXEC && memb.rdata.deact && !memb.rdata.avail_b7 && qfn == FST_FN_READ
      |=> !q.qres;
  endproperty
  a_plain_deact: assert property (p_plain_deact) else $error("deactivated file readable"); // R5
  property p_b7_deact;
    q.st == FST_QEXEC && idx_ok(q.fidx) && memb.rdata.avail_b7 && qfn == FST_FN_UPDATE
      |=> q.qres;
  endproperty
  a_b7_deact: assert property (p_b7_deact) else $error("b7 file not updatable"); // R6
  property p_dsw;
    q.st == FST_EXEC ##1 q.sw == `FST_SW_DMORE |-> q.dphase && !q.ddone && q.dcnt < totd;
  endproperty
  a_dsw: assert property (p_dsw) else $error("63F1 with data complete"); // R15
  property p_calc_start;
    calb.start |-> q.st == FST_EXEC && (kind == FST_K_AUTH_EVEN || blk == `FST_BLK_RFIRST)
      ##1 q.st == FST_CALC;
  endproperty
  a_calc_start: assert property (p_calc_start) else $error("compute started early"); // R16
  property p_rsw;
    q.st == FST_CALC && calb.done && kind == FST_K_AUTH_ODD
      |=> (q.sw == `FST_SW_OK) == (q.roff >= totr);
  endproperty
  a_rsw: assert property (p_rsw) else $error("response status wrong"); // R17
  property p_c_susp;
    q.st == FST_EXEC && kind == FST_K_SUSPEND && memb.we;
  endproperty
  c_susp: cover property (p_c_susp);
  property p_c_data_done;
    q.st == FST_EXEC ##1 q.sw == `FST_SW_DDONE;
  endproperty
  c_data_done: cover property (p_c_data_done);
  property p_c_resp_more;
    q.st == FST_EXEC ##1 q.sw == `FST_SW_RMORE;
  endproperty
  c_resp_more: cover property (p_c_resp_more);
endmodule : fst_top
`default_nettype wire

//--- tb/fst_term.sv
// Terminal model driving the card's register bus
`timescale 1ns/1ps
`default_nettype none
module fst_term (
  input  wire logic        clk_i,
  input  wire logic [31:0] dat_i,
  input  wire logic        ack_i,
  output logic             cyc_o,
  output logic             we_o,
  output logic [7:0]       adr_o,
  output logic [31:0]      dat_o
);
  initial
  begin
    cyc_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 8'h00;
    dat_o = 32'h0;
  end
  // ====================
  // Bus cycle
  // Request held until ack is sampled; no cycle count assumed
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    cyc_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    dat_o <= d;
    @(posedge clk_i);
    while (ack_i !== 1'b1)
      @(posedge clk_i);
    q = dat_i;
    cyc_o <= 1'b0;
    @(posedge clk_i);
  endtask : xfer
  // ====================
  // Command issue
  // caller sets app flag, lengths, repeated fields
  task automatic cmd(input logic [31:0] c, output logic [15:0] sw);
    logic [31:0] q;
    xfer(1'b1, 8'h00, c, q);
    q = 32'h8000_0000;
    while (q[31])
      xfer(1'b0, 8'h00, 32'h0, q);
    xfer(1'b0, 8'h10, 32'h0, q);
    sw = q[15:0];
  endtask : cmd
endmodule : fst_term
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the command interpreter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc, we, ack;
  logic [7:0]  adr;
  logic [31:0] wd, rd, q;
  logic [15:0] sw;
  int          bad_count = 0, n_checks = 0, cyc_n = 0;
  int          cur = 0, dir = 0, seed = 32'ha539, r, dn, lens[$];
  bit          dea [256];
  logic [15:0] ev [4] = '{16'h0000, 16'h8100, 16'h0001, 16'h6000};
  logic [11:0] fq [6] = '{12'ha07, 12'hb07, 12'h407, 12'h208, 12'h808, 12'h908};
  always #2 clk_i = ~clk_i;
  fst_top #(.CALC_CYCLES(2)) i_fst_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd),
    .wb_dat_o(rd), .wb_ack_o(ack));
  fst_term i_fst_term (.clk_i(clk_i), .dat_i(rd), .ack_i(ack), .cyc_o(cyc),
    .we_o(we), .adr_o(adr), .dat_o(wd));
  // Hang guard
  always @(posedge clk_i)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000)
    begin
      bad_count++;
      report_and_stop();
    end
  end
  // ====================
  // Helpers
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_fst_term.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    i_fst_term.xfer(1'b0, a, 32'h0, q);
  endtask : rdr
  // Query result lands two edges after the write, so wait for idle first
  task automatic qry(input logic [10:0] v);
    wr(8'h18, {21'h0, v});
    q = 32'h8000_0000;
    while (q[31])
      rdr(8'h00);
    rdr(8'h18);
  endtask : qry
  // File command against the integer model of file states
  task automatic fcmd(input int k, input logic [7:0] p1, p2, input bit dt, input int ix, acc);
    int t, e;
    t = (p1 == 0 && !dt) ? cur : ix;
    e = (!(p1 inside {8'h00, 8'h08, 8'h09}) || p2 != 0) ? 'h6a86 : (acc ? 'h9000 : 'h6982);
    wr(8'h04, {16'h3c, 6'h0, 1'b1, acc[0], ix[7:0]});
    i_fst_term.cmd({8'h0, p2, p1, 5'h0, dt, k[1:0]}, sw);
    chk("sw", e, sw);
    if (e == 'h9000)
    begin
      dea[t] = (k == 0);
      cur = t;
      if (p1 != 0)
        dir = 'h3c;
    end
    rdr(8'h10);
    chk("cur", {dir[7:0], cur[7:0]}, q[31:16]);
    qry({3'd2, t[7:0]});
    chk("read ok", !dea[t], q[0]);
  endtask : fcmd
  // Odd authentication block; P1 carries the block code
  task automatic auth(input logic [2:0] b, input int l, input logic [7:0] tg,
                      input bit ap, input int e);
    wr(8'h04, {tg, 14'h0, ap, 1'b1, 8'h0});
    wr(8'h08, b[0] ? l << 16 : l);
    i_fst_term.cmd({16'h0, b, 5'h0, 4'h0, b[0], ~b[0], 2'b11}, sw);
    chk("auth sw", e, sw);
  endtask : auth
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  // ====================
  // Sequence
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdr(8'h10);
    chk("stat", 32'h9000, q);
    fcmd(0, 8'h00, 8'h00, 1, 5, 0);
    fcmd(0, 8'h00, 8'h00, 1, 5, 1);
    fcmd(1, 8'h00, 8'h00, 0, 9, 1);
    fcmd(0, 8'h01, 8'h00, 1, 6, 1);
    fcmd(1, 8'h09, 8'h02, 1, 6, 1);
    repeat (6) fcmd($random(seed) & 1, $random(seed) & 1 ? 8'h08 : 8'h09, 8'h00, 1,
                    $random(seed) & 255, 1);
    $display("file tests done");
    wr(8'h14, 32'h307);
    wr(8'h14, 32'h108);
    foreach (fq[i])
    begin
      qry(fq[i][10:0]);
      chk("allowed", fq[i][11], q[0]);
    end
    $display("availability tests done");
    wr(8'h0c, {16'd300, 16'd300});
    auth(3'b100, 20, 8'h11, 1, 'h6a80);
    auth(3'b100, 20, 8'h73, 0, 'h6985);
    auth(3'b110, 20, 8'h73, 1, 'h6a86);
    auth(3'b100, 256, 8'h73, 1, 'h6700);
    r = $unsigned($random(seed)) % 44 + 1;
    lens = {255, r, 45 - r};
    dn = 0;
    foreach (lens[i])
    begin
      dn += lens[i];
      auth(i ? 3'b000 : 3'b100, lens[i], 8'h53, 1, dn < 300 ? 'h63f1 : 'h62f3);
    end
    auth(3'b010, 45 - r, 8'h53, 1, 'h62f3);
    auth(3'b000, 1, 8'h53, 1, 'h6985);
    rdr(8'h18);
    chk("calc early", 32'h0, q[3]);
    auth(3'b101, 256, 8'h73, 1, 'h62f1);
    auth(3'b011, 256, 8'h73, 1, 'h62f1);
    auth(3'b001, 256, 8'h73, 1, 'h9000);
    rdr(8'h1c);
    chk("info", {16'd300, 16'd300}, q);
    $display("odd chain tests done");
    foreach (ev[i])
    begin
      wr(8'h08, {7'h0, 9'd16, 7'h0, 9'd16});
      i_fst_term.cmd({8'h0, ev[i], 8'h0e}, sw);
      chk("even sw", (ev[i][7:0] != 0 || ev[i][14:13] != 0) ? 'h6a86 : 'h9000, sw);
    end
    rdr(8'h18);
    chk("key", 6'h21, q[13:8]);
    $display("even tests done");
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
